// *** design/cafr_pkg.sv ***
// package for the receive acceptance filter block: register map, fields, resets
// assumes a 32-bit AXI4-Lite register bus with word-aligned byte addresses
package cafr_pkg;
  localparam int CAFR_NUM_FILT = 16;
  localparam int CAFR_NUM_MASK = 3;
  localparam int CAFR_NUM_BUF = 16;
  // byte offsets of the register words
  localparam logic [7:0] CAFR_OFS_FILT_EN = 8'h00;
  localparam logic [7:0] CAFR_OFS_PNT_BASE = 8'h04;
  localparam logic [7:0] CAFR_OFS_MSKSEL_BASE = 8'h14;
  localparam logic [7:0] CAFR_OFS_FULL = 8'h1C;
  localparam logic [7:0] CAFR_OFS_OVF = 8'h20;
  localparam logic [7:0] CAFR_OFS_MASK_BASE = 8'h40;
  localparam logic [7:0] CAFR_OFS_FILT_BASE = 8'h80;
  // fields of the standard-id pattern word
  localparam int CAFR_SID_LSB = 5;
  localparam int CAFR_FILTER_EXT_FRAME_SELECT_BIT = 3;
  localparam int CAFR_EIDH_LSB = 0;
  localparam logic [15:0] CAFR_SID_WMASK = 16'hFFEB;
  // reset values, fifo pointer code and bus response codes
  localparam logic [15:0] CAFR_RST_FILT_EN = 16'hFFFF;
  localparam logic [15:0] CAFR_RST_ZERO = 16'h0000;
  localparam logic [3:0] CAFR_PTR_FIFO = 4'hF;
  localparam logic [1:0] CAFR_AXI_OKAY = 2'b00;
  localparam logic [1:0] CAFR_AXI_SLVERR = 2'b10;
endpackage

// *** design/cafr_match.sv ***
// one acceptance filter compare: pattern against frame under the selected mask
// assumes pattern, mask and frame fields are stable for the decision cycle
`timescale 1ns/100ps
`default_nettype none
module cafr_match
  import cafr_pkg::*;
(
  // frame
  input wire logic [28:0] frame_id_in,
  input wire logic frame_ext_in,
  // filter and mask
  input wire logic [28:0] pat_id_in,
  input wire logic pat_ext_in,
  input wire logic [28:0] mask_id_in,
  input wire logic mask_type_in,
  input wire logic enable_in,
  // result
  output logic hit_out
);
  logic id_ok; // masked id agrees
  logic type_ok; // frame format agrees
  logic [28:0] cmp_id; // frame id aligned to compare lanes
  // standard frames only carry the top 11 bits; extended bits are then zero
  always_comb
  begin
    cmp_id = frame_ext_in ? frame_id_in : {frame_id_in[28:18], 18'h00000};
    id_ok = (((cmp_id ^ pat_id_in) & mask_id_in) == 29'h00000000);
    type_ok = !mask_type_in || (frame_ext_in == pat_ext_in);
    hit_out = enable_in && id_ok && type_ok;
  end
endmodule
`default_nettype wire

// *** design/cafr_top.sv ***
// acceptance filtering and buffer steering with an AXI4-Lite register slave
// assumes the protocol engine pulses FRAME_VALID_IN once per decoded identifier
`timescale 1ns/100ps
`default_nettype none
module cafr_top
  import cafr_pkg::*;
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // axi4-lite write address and data
  input wire logic [7:0] S_AWADDR_IN,
  input wire logic S_AWVALID_IN,
  output logic S_AWREADY_OUT,
  input wire logic [31:0] S_WDATA_IN,
  input wire logic [3:0] S_WSTRB_IN,
  input wire logic S_WVALID_IN,
  output logic S_WREADY_OUT,
  // axi4-lite write response
  output logic [1:0] S_BRESP_OUT,
  output logic S_BVALID_OUT,
  input wire logic S_BREADY_IN,
  // axi4-lite read
  input wire logic [7:0] S_ARADDR_IN,
  input wire logic S_ARVALID_IN,
  output logic S_ARREADY_OUT,
  output logic [31:0] S_RDATA_OUT,
  output logic [1:0] S_RRESP_OUT,
  output logic S_RVALID_OUT,
  input wire logic S_RREADY_IN,
  // frame from protocol engine
  input wire logic FRAME_VALID_IN,
  input wire logic [28:0] FRAME_ID_IN,
  input wire logic FRAME_EXT_IN,
  // steering result
  output logic ACCEPT_OUT,
  output logic ACCEPT_FIFO_OUT,
  output logic [3:0] ACCEPT_BUF_OUT,
  output logic [3:0] ACCEPT_FILT_OUT
);
  // register state
  logic [15:0] filt_en_q, filt_en_d; // filter_enable bits
  logic [15:0] pnt_q [4], pnt_d [4]; // filter_dest_pointer words
  logic [15:0] msksel_q [2], msksel_d [2]; // filter_mask_source words
  logic [15:0] sid_q [CAFR_NUM_FILT], sid_d [CAFR_NUM_FILT];
  logic [15:0] eid_q [CAFR_NUM_FILT], eid_d [CAFR_NUM_FILT];
  logic [15:0] msid_q [CAFR_NUM_MASK], msid_d [CAFR_NUM_MASK];
  logic [15:0] meid_q [CAFR_NUM_MASK], meid_d [CAFR_NUM_MASK];
  logic [15:0] full_q, full_d; // rx_buffer_full_flag
  logic [15:0] ovf_q, ovf_d; // rx_buffer_overflow_flag
  // bus state
  logic aw_held_q, aw_held_d; // address taken, waiting data
  logic w_held_q, w_held_d; // data taken, waiting address
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d; // readies kept in flops
  // frame result state
  logic acc_q, acc_d;
  logic fifo_q, fifo_d;
  logic [3:0] buf_q, buf_d;
  logic [3:0] filt_q, filt_d;
  // per-filter compare
  logic [CAFR_NUM_FILT-1:0] hit; // raw hits
  logic [28:0] pat_id [CAFR_NUM_FILT];
  logic [1:0] msrc [CAFR_NUM_FILT];
  logic [28:0] mk_id [CAFR_NUM_FILT];
  logic mk_type [CAFR_NUM_FILT];
  logic [3:0] fptr [CAFR_NUM_FILT];
  // write decode helpers
  logic wr_go; // both halves present
  logic [7:0] wa; // effective write address
  logic [31:0] wd;
  logic [3:0] ws;
  logic wr_ok;
  logic [15:0] wmask; // byte-lane mask low half
  logic [3:0] win_idx; // winning filter
  logic win_any;

  // fan out per filter fields and compare engines
  genvar g;
  generate
    for (g = 0; g < CAFR_NUM_FILT; g++)
    begin : gen_filt
      always_comb
      begin
        pat_id[g] = {sid_q[g][15:CAFR_SID_LSB], sid_q[g][CAFR_EIDH_LSB+:2], eid_q[g]};
        msrc[g] = msksel_q[g/8][(g%8)*2+:2];
        // reserved code 11 is left to software; treat as mask 2
        mk_id[g] = (msrc[g] == 2'b00) ? {msid_q[0][15:5], msid_q[0][1:0], meid_q[0]} :
                   (msrc[g] == 2'b01) ? {msid_q[1][15:5], msid_q[1][1:0], meid_q[1]} :
                                        {msid_q[2][15:5], msid_q[2][1:0], meid_q[2]};
        mk_type[g] = (msrc[g] == 2'b00) ? msid_q[0][CAFR_FILTER_EXT_FRAME_SELECT_BIT] :
                     (msrc[g] == 2'b01) ? msid_q[1][CAFR_FILTER_EXT_FRAME_SELECT_BIT] :
                                          msid_q[2][CAFR_FILTER_EXT_FRAME_SELECT_BIT];
        fptr[g] = pnt_q[g/4][(g%4)*4+:4];
      end
      cafr_match u_match
      (
        .frame_id_in(FRAME_ID_IN),
        .frame_ext_in(FRAME_EXT_IN),
        .pat_id_in(pat_id[g]),
        .pat_ext_in(sid_q[g][CAFR_FILTER_EXT_FRAME_SELECT_BIT]),
        .mask_id_in(mk_id[g]),
        .mask_type_in(mk_type[g]),
        .enable_in(filt_en_q[g]),
        .hit_out(hit[g])
      );
    end
  endgenerate

  // priority pick: lowest index wins, single cycle so well inside a frame time
  always_comb
  begin
    win_idx = 4'h0;
    win_any = 1'b0;
    for (int i = CAFR_NUM_FILT - 1; i >= 0; i--)
    begin
      if (hit[i])
      begin
        win_idx = 4'(i);
        win_any = 1'b1;
      end
    end
  end

  // write channel pairing; address and data may arrive in either order
  always_comb
  begin
    wa = aw_held_q ? awaddr_q : S_AWADDR_IN;
    wd = w_held_q ? wdata_q : S_WDATA_IN;
    ws = w_held_q ? wstrb_q : S_WSTRB_IN;
    wr_go = (aw_held_q || S_AWVALID_IN) && (w_held_q || S_WVALID_IN) && !bvalid_q;
    wmask = {{8{ws[1]}}, {8{ws[0]}}};
    wr_ok = (wa[1:0] == 2'b00) && ((wa < 8'h24) ||
            (wa >= CAFR_OFS_MASK_BASE && wa < 8'h58) || (wa >= CAFR_OFS_FILT_BASE));
  end

  // next state of registers, bus and steering outputs
  always_comb
  begin
    filt_en_d = filt_en_q;
    pnt_d = pnt_q;
    msksel_d = msksel_q;
    sid_d = sid_q;
    eid_d = eid_q;
    msid_d = msid_q;
    meid_d = meid_q;
    full_d = full_q;
    ovf_d = ovf_q;
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    acc_d = 1'b0;
    fifo_d = 1'b0;
    buf_d = buf_q;
    filt_d = filt_q;
    // hold halves that arrive alone; never while a response stands, or a half is taken twice
    if (!wr_go && S_AWVALID_IN && !aw_held_q && !bvalid_q)
    begin
      aw_held_d = 1'b1;
      awaddr_d = S_AWADDR_IN;
    end
    if (!wr_go && S_WVALID_IN && !w_held_q && !bvalid_q)
    begin
      w_held_d = 1'b1;
      wdata_d = S_WDATA_IN;
      wstrb_d = S_WSTRB_IN;
    end
    // register write
    if (wr_go)
    begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_ok ? CAFR_AXI_OKAY : CAFR_AXI_SLVERR;
      if (wr_ok)
      begin
        if (wa == CAFR_OFS_FILT_EN)
          filt_en_d = (filt_en_q & ~wmask) | (wd[15:0] & wmask);
        else if (wa == CAFR_OFS_FULL)
          full_d = full_q & (wd[15:0] | ~wmask);
        else if (wa == CAFR_OFS_OVF)
          ovf_d = ovf_q & (wd[15:0] | ~wmask);
        else if (wa < CAFR_OFS_MSKSEL_BASE)
          pnt_d[wa[3:2] - 2'd1] = (pnt_q[wa[3:2] - 2'd1] & ~wmask) | (wd[15:0] & wmask);
        else if (wa < CAFR_OFS_FULL)
          msksel_d[wa[2] ^ 1'b1] = (msksel_q[wa[2] ^ 1'b1] & ~wmask) | (wd[15:0] & wmask);
        else if (wa < CAFR_OFS_FILT_BASE)
        begin
          if (wa[2])
            meid_d[wa[4:3]] = (meid_q[wa[4:3]] & ~wmask) | (wd[15:0] & wmask);
          else
            msid_d[wa[4:3]] = (msid_q[wa[4:3]] & ~wmask) | (wd[15:0] & wmask & CAFR_SID_WMASK);
        end
        else if (wa[2])
          eid_d[wa[6:3]] = (eid_q[wa[6:3]] & ~wmask) | (wd[15:0] & wmask);
        else
          sid_d[wa[6:3]] = (sid_q[wa[6:3]] & ~wmask) | (wd[15:0] & wmask & CAFR_SID_WMASK);
      end
    end
    if (bvalid_q && S_BREADY_IN)
      bvalid_d = 1'b0;
    // register read
    if (S_ARVALID_IN && !rvalid_q)
    begin
      rvalid_d = 1'b1;
      rresp_d = CAFR_AXI_OKAY;
      rdata_d = 32'h00000000;
      if (S_ARADDR_IN[1:0] != 2'b00)
        rresp_d = CAFR_AXI_SLVERR;
      else if (S_ARADDR_IN == CAFR_OFS_FILT_EN)
        rdata_d[15:0] = filt_en_q;
      else if (S_ARADDR_IN == CAFR_OFS_FULL)
        rdata_d[15:0] = full_q;
      else if (S_ARADDR_IN == CAFR_OFS_OVF)
        rdata_d[15:0] = ovf_q;
      else if (S_ARADDR_IN > CAFR_OFS_FILT_EN && S_ARADDR_IN < CAFR_OFS_MSKSEL_BASE)
        rdata_d[15:0] = pnt_q[S_ARADDR_IN[3:2] - 2'd1];
      else if (S_ARADDR_IN >= CAFR_OFS_MSKSEL_BASE && S_ARADDR_IN < CAFR_OFS_FULL)
        rdata_d[15:0] = msksel_q[S_ARADDR_IN[2] ^ 1'b1];
      else if (S_ARADDR_IN >= CAFR_OFS_MASK_BASE && S_ARADDR_IN < 8'h58)
        rdata_d[15:0] = S_ARADDR_IN[2] ? meid_q[S_ARADDR_IN[4:3]] : msid_q[S_ARADDR_IN[4:3]];
      else if (S_ARADDR_IN >= CAFR_OFS_FILT_BASE)
        rdata_d[15:0] = S_ARADDR_IN[2] ? eid_q[S_ARADDR_IN[6:3]] : sid_q[S_ARADDR_IN[6:3]];
      else
        rresp_d = CAFR_AXI_SLVERR;
    end
    else if (rvalid_q && S_RREADY_IN)
      rvalid_d = 1'b0;
    // frame steering; hardware set is applied last so it beats a clear
    if (FRAME_VALID_IN && win_any)
    begin
      acc_d = 1'b1;
      filt_d = win_idx;
      buf_d = fptr[win_idx];
      if (fptr[win_idx] == CAFR_PTR_FIFO)
        fifo_d = 1'b1;
      else
      begin
        if (full_q[fptr[win_idx]])
          ovf_d[fptr[win_idx]] = 1'b1;
        full_d[fptr[win_idx]] = 1'b1;
      end
    end
    // readies from next holding state, so each stands as a flop output
    awrdy_d = !aw_held_d && !bvalid_d;
    wrdy_d = !w_held_d && !bvalid_d;
    arrdy_d = !rvalid_d;
  end

  // register all state
  always_ff @(posedge CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      filt_en_q <= CAFR_RST_FILT_EN;
      pnt_q <= '{default: CAFR_RST_ZERO};
      msksel_q <= '{default: CAFR_RST_ZERO};
      sid_q <= '{default: CAFR_RST_ZERO};
      eid_q <= '{default: CAFR_RST_ZERO};
      msid_q <= '{default: CAFR_RST_ZERO};
      meid_q <= '{default: CAFR_RST_ZERO};
      full_q <= CAFR_RST_ZERO;
      ovf_q <= CAFR_RST_ZERO;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= CAFR_AXI_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= CAFR_AXI_OKAY;
      acc_q <= 1'b0;
      fifo_q <= 1'b0;
      buf_q <= 4'h0;
      filt_q <= 4'h0;
      awrdy_q <= 1'b1;
      wrdy_q <= 1'b1;
      arrdy_q <= 1'b1;
    end
    else
    begin
      filt_en_q <= filt_en_d;
      pnt_q <= pnt_d;
      msksel_q <= msksel_d;
      sid_q <= sid_d;
      eid_q <= eid_d;
      msid_q <= msid_d;
      meid_q <= meid_d;
      full_q <= full_d;
      ovf_q <= ovf_d;
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      acc_q <= acc_d;
      fifo_q <= fifo_d;
      buf_q <= buf_d;
      filt_q <= filt_d;
      awrdy_q <= awrdy_d;
      wrdy_q <= wrdy_d;
      arrdy_q <= arrdy_d;
    end
  end

  // outputs straight from flops; readies show what the next edge accepts
  assign S_AWREADY_OUT = awrdy_q;
  assign S_WREADY_OUT = wrdy_q;
  assign S_ARREADY_OUT = arrdy_q;
  assign S_BVALID_OUT = bvalid_q;
  assign S_BRESP_OUT = bresp_q;
  assign S_RVALID_OUT = rvalid_q;
  assign S_RDATA_OUT = rdata_q;
  assign S_RRESP_OUT = rresp_q;
  assign ACCEPT_OUT = acc_q;
  assign ACCEPT_FIFO_OUT = fifo_q;
  assign ACCEPT_BUF_OUT = buf_q;
  assign ACCEPT_FILT_OUT = filt_q;
endmodule
`default_nettype wire

// *** sim/cafr_properties.sv ***
// checker on the filter block's bus and steering ports
// assumes a bind onto cafr_top and a single clock
`timescale 1ns/100ps
`default_nettype none
module cafr_properties
  import cafr_pkg::*;
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // register bus
  input wire logic S_AWREADY_OUT,
  input wire logic S_BVALID_OUT,
  input wire logic S_BREADY_IN,
  input wire logic [1:0] S_BRESP_OUT,
  input wire logic S_ARVALID_IN,
  input wire logic S_ARREADY_OUT,
  input wire logic S_RVALID_OUT,
  input wire logic S_RREADY_IN,
  input wire logic [31:0] S_RDATA_OUT,
  // frames and steering
  input wire logic FRAME_VALID_IN,
  input wire logic ACCEPT_OUT,
  input wire logic ACCEPT_FIFO_OUT,
  input wire logic [3:0] ACCEPT_BUF_OUT
);
  // one domain, so clock and reset are stated once
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RESET_IN);
  chk_accept_cause:
    assert property (ACCEPT_OUT |-> $past(FRAME_VALID_IN))
    else $error("accept without a frame one cycle earlier");
  chk_fifo_code:
    assert property (ACCEPT_FIFO_OUT |-> ACCEPT_OUT && ACCEPT_BUF_OUT == CAFR_PTR_FIFO)
    else $error("fifo pulse without fifo pointer");
  chk_buf_code:
    assert property (ACCEPT_OUT && ACCEPT_BUF_OUT != CAFR_PTR_FIFO |-> !ACCEPT_FIFO_OUT)
    else $error("buffer pointer steered to fifo");
  chk_dest_hold:
    assert property (!ACCEPT_OUT |-> $stable(ACCEPT_BUF_OUT))
    else $error("destination moved without accept");
  chk_bresp_hold:
    assert property (S_BVALID_OUT && !S_BREADY_IN |=> S_BVALID_OUT && $stable(S_BRESP_OUT))
    else $error("write response dropped early");
  chk_rdata_hold:
    assert property (S_RVALID_OUT && !S_RREADY_IN |=> S_RVALID_OUT && $stable(S_RDATA_OUT))
    else $error("read data dropped early");
  chk_read_latency:
    assert property (S_ARVALID_IN && S_ARREADY_OUT |=>
      S_RVALID_OUT && S_RDATA_OUT[31:16] == 16'h0000)
    else $error("read answer late or upper half set");
  chk_aw_blocked:
    assert property (S_BVALID_OUT |-> !S_AWREADY_OUT)
    else $error("write address open while response pending");
  cov_fifo: cover property (ACCEPT_FIFO_OUT);
  cov_buffer: cover property (ACCEPT_OUT && !ACCEPT_FIFO_OUT);
  cov_stall: cover property (S_BVALID_OUT && !S_BREADY_IN);
endmodule
bind cafr_top cafr_properties chk_u (
  .CLK_IN(CLK_IN),
  .RESET_IN(RESET_IN),
  .S_AWREADY_OUT(S_AWREADY_OUT),
  .S_BVALID_OUT(S_BVALID_OUT),
  .S_BREADY_IN(S_BREADY_IN),
  .S_BRESP_OUT(S_BRESP_OUT),
  .S_ARVALID_IN(S_ARVALID_IN),
  .S_ARREADY_OUT(S_ARREADY_OUT),
  .S_RVALID_OUT(S_RVALID_OUT),
  .S_RREADY_IN(S_RREADY_IN),
  .S_RDATA_OUT(S_RDATA_OUT),
  .FRAME_VALID_IN(FRAME_VALID_IN),
  .ACCEPT_OUT(ACCEPT_OUT),
  .ACCEPT_FIFO_OUT(ACCEPT_FIFO_OUT),
  .ACCEPT_BUF_OUT(ACCEPT_BUF_OUT)
);
`default_nettype wire

// *** sim/cafr_engine.sv ***
// protocol engine model: one-cycle identifier pulses
// assumes the controller clock drives clk_in
`timescale 1ns/100ps
`default_nettype none
module cafr_engine
  import cafr_pkg::*;
(
  // clock
  input wire logic clk_in,
  // decoded frame
  output var logic valid_out,
  output var logic [28:0] id_out,
  output var logic ext_out
);
  // idle until the first frame
  initial
  begin
    valid_out = 1'b0;
    id_out = 29'h00000000;
    ext_out = 1'b0;
  end
  // one frame; released lines are inverted so nothing leans on stale ids
  task automatic send(input logic [28:0] id, input logic ext);
    @(posedge clk_in);
    valid_out <= 1'b1;
    id_out <= id;
    ext_out <= ext;
    @(posedge clk_in);
    valid_out <= 1'b0;
    id_out <= ~id;
    ext_out <= ~ext;
  endtask
endmodule
`default_nettype wire

// *** sim/can_rx_acceptance_filter_tb_top.sv ***
// bench for the acceptance filter: setup over the bus, frame table, flags
// assumes cafr_engine drives frames and the checker is bound to the design
`timescale 1ns/100ps
`default_nettype none
module can_rx_acceptance_filter_tb_top
  import cafr_pkg::*;
;
  typedef struct packed {logic [28:0] id; logic ext; logic [9:0] exp;} cafr_row_t;
  // clock, reset and bus master drive
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
  logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic [31:0] w_d = 32'h00000000;
  logic [3:0] w_s = 4'h3; // write strobes, both low lanes unless a test narrows them
  // design outputs and frame lines
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, acc, acc_f, f_v, f_x;
  logic [1:0] b_resp, r_resp;
  logic [31:0] r_d;
  logic [3:0] acc_b, acc_n;
  logic [28:0] f_id;
  int bad_count = 0, n_compared = 0, cyc = 0;
  // setup writes, address in the top byte; no mask source uses code 11
  logic [23:0] cfg [11] = '{24'h00800E, 24'h48FFEB, 24'h4CFFFF, 24'h50FFE0,
    24'h140094, 24'h040E50, 24'h10F000, 24'h88246A, 24'h8CABCD, 24'h90FFE0, 24'h982460};
  // frames: expected {accept, fifo, buffer, filter}
  cafr_row_t rows [6] = '{'{29'h048EABCD, 1'b1, 10'h251}, '{29'h1FFC0000, 1'b0, 10'h2E2},
    '{29'h048C0000, 1'b0, 10'h203}, '{29'h048C0001, 1'b1, 10'h203},
    '{29'h1FFC0000, 1'b1, 10'h3FF}, '{29'h00040000, 1'b0, 10'h3FF}};
  always #10 clk = ~clk;
  cafr_top dut_u (
    .CLK_IN(clk),
    .RESET_IN(rst),
    .S_AWADDR_IN(aw_a),
    .S_AWVALID_IN(aw_v),
    .S_AWREADY_OUT(aw_rdy),
    .S_WDATA_IN(w_d),
    .S_WSTRB_IN(w_s),
    .S_WVALID_IN(w_v),
    .S_WREADY_OUT(w_rdy),
    .S_BRESP_OUT(b_resp),
    .S_BVALID_OUT(b_v),
    .S_BREADY_IN(b_r),
    .S_ARADDR_IN(ar_a),
    .S_ARVALID_IN(ar_v),
    .S_ARREADY_OUT(ar_rdy),
    .S_RDATA_OUT(r_d),
    .S_RRESP_OUT(r_resp),
    .S_RVALID_OUT(r_v),
    .S_RREADY_IN(r_r),
    .FRAME_VALID_IN(f_v),
    .FRAME_ID_IN(f_id),
    .FRAME_EXT_IN(f_x),
    .ACCEPT_OUT(acc),
    .ACCEPT_FIFO_OUT(acc_f),
    .ACCEPT_BUF_OUT(acc_b),
    .ACCEPT_FILT_OUT(acc_n)
  );
  cafr_engine eng_u (
    .clk_in(clk),
    .valid_out(f_v),
    .id_out(f_id),
    .ext_out(f_x)
  );
  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // write; bready rises late so the response has to stand
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = CAFR_AXI_OKAY);
    @(posedge clk);
    aw_a <= a;
    aw_v <= 1'b1;
    w_d <= {16'h0000, d};
    w_v <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (b_v && b_r) break;
      if (aw_rdy) aw_v <= 1'b0;
      if (w_rdy) w_v <= 1'b0;
      b_r <= b_v;
    end
    b_r <= 1'b0;
    chk({38'h0, b_resp}, {38'h0, er});
  endtask
  // read and compare response code and data
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    ar_a <= a;
    ar_v <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (r_v && r_r) break;
      if (ar_rdy) ar_v <= 1'b0;
      r_r <= r_v;
    end
    r_r <= 1'b0;
    chk({6'h00, r_resp, r_d}, {6'h00, er, e});
  endtask
  // one frame, steering looked at in the cycle after it is taken
  task automatic frame(input cafr_row_t r);
    eng_u.send(r.id, r.ext);
    #1;
    chk({30'h0, acc, acc_f, acc_b, acc_n}, {30'h0, r.exp});
  endtask
  // hang guard, far above the roughly 130 cycles needed
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      bad_count++;
      final_report();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdc(CAFR_OFS_FILT_EN, 32'h0000FFFF, CAFR_AXI_OKAY);
    rdc(CAFR_OFS_MSKSEL_BASE, 32'h00000000, CAFR_AXI_OKAY);
    rdc(8'h10, 32'h00000000, CAFR_AXI_OKAY);
    rdc(CAFR_OFS_FULL, 32'h00000000, CAFR_AXI_OKAY);
    rdc(8'h3C, 32'h00000000, CAFR_AXI_SLVERR);
    wr(8'h3C, 16'h1234, CAFR_AXI_SLVERR);
    wr(CAFR_OFS_FILT_BASE, 16'hFFFF);
    rdc(CAFR_OFS_FILT_BASE, {16'h0000, CAFR_SID_WMASK}, CAFR_AXI_OKAY);
    foreach (cfg[i]) wr(cfg[i][23:16], cfg[i][15:0]);
    foreach (rows[i]) frame(rows[i]);
    rdc(CAFR_OFS_FULL, 32'h00004021, CAFR_AXI_OKAY);
    rdc(CAFR_OFS_OVF, 32'h00000001, CAFR_AXI_OKAY);
    wr(CAFR_OFS_FULL, 16'hFFDF);
    rdc(CAFR_OFS_FULL, 32'h00004001, CAFR_AXI_OKAY);
    wr(CAFR_OFS_OVF, 16'h0000);
    rdc(CAFR_OFS_OVF, 32'h00000000, CAFR_AXI_OKAY);
    wr(CAFR_OFS_FILT_EN, 16'h000C);
    // high lane strobed off: the upper enable byte must keep its zeros
    w_s <= 4'h1;
    wr(CAFR_OFS_FILT_EN, 16'hFF0C);
    w_s <= 4'h3;
    rdc(CAFR_OFS_FILT_EN, 32'h0000000C, CAFR_AXI_OKAY);
    frame('{29'h048EABCD, 1'b1, 10'h203});
    frame('{29'h00040000, 1'b0, 10'h003});
    final_report();
  end
endmodule
`default_nettype wire
